// file: verilog/sta_map.svh
// Purpose: offsets, field positions, reset values and counts of the trigger/acquisition block
// Assumes: included by its bare name
// Notes: register index = byte address / 4
`ifndef STA_MAP_SVH
`define STA_MAP_SVH
`define STA_ADDR_W        6
`define STA_REG_CTRL      6'h00
`define STA_REG_TRIG      6'h04
`define STA_REG_LEVELS    6'h08
`define STA_REG_POST      6'h0c
`define STA_REG_HOLD      6'h10
`define STA_REG_AUTO_TO   6'h14
`define STA_REG_HPOS      6'h18
`define STA_REG_STATUS    6'h1c
`define STA_REG_CMD       6'h20
`define STA_REG_RDPTR     6'h24
`define STA_REG_RDDATA    6'h28
// ctrl fields
`define STA_CTRL_RUN      0
`define STA_CTRL_ROLL     1
`define STA_CTRL_LOGSRC   2
`define STA_CTRL_TYPE_LO  4
`define STA_CTRL_TB_LO    8
`define STA_CTRL_GAIN_LO  16
`define STA_CTRL_LBIT_LO  20
// trig fields
`define STA_TRIG_EDGE     0
`define STA_TRIG_WIN      1
`define STA_TRIG_SLOPE    2
`define STA_TRIG_DIR      3
`define STA_TRIG_SRC_CH2  4
// cmd fields
`define STA_CMD_TOGGLE    0
`define STA_CMD_CENTER    1
// timebase steps: 0..10 fast, 11..21 slow
`define STA_TB_LAST_FAST  5'h0a
`define STA_TB_LAST       5'h15
`define STA_TB_FASTEST    5'h00
`define STA_GAIN_LAST     3'h6
`define STA_POST_MAX      16'h8000
`define STA_POST_RST      17'h00080
`define STA_HPOS_CENTER   8'h40
`define STA_HPOS_LAST     8'h80
`define STA_AUTO_TO_RST   32'h000f4240
`endif

// file: verilog/sta_pkg.sv
// Purpose: types of the trigger/acquisition block
// Assumes: none
// Notes: none
package sta_pkg;
   typedef enum logic [1:0] {
      STA_NORMAL = 2'b00,
      STA_SINGLE = 2'b01,
      STA_AUTO   = 2'b10,
      STA_FREE   = 2'b11
   } sta_type_t;

   typedef enum logic [1:0] {
      STA_IDLE    = 2'b00,
      STA_ARMED   = 2'b01,
      STA_POST    = 2'b10,
      STA_STOPPED = 2'b11
   } sta_state_t;

   typedef struct packed {
      logic [7:0] first_analog_channel;
      logic [7:0] second_analog_channel;
      logic [7:0] logic_in;
   } sta_sample_t;

   typedef struct packed {
      logic        valid;
      logic        second_shown;
      sta_sample_t smp;
   } sta_disp_t;

   typedef struct packed {
      sta_state_t  fsm;
      logic        run;
      logic        roll;
      logic        logsrc;
      sta_type_t   ttype;
      logic [4:0]  tb;
      logic [2:0]  gain;
      logic [2:0]  lbit;
      logic        m_edge;
      logic        m_win;
      logic        m_slope;
      logic        dir;
      logic        src_ch2;
      logic [7:0]  level;
      logic [7:0]  win_hi;
      logic [7:0]  slope_th;
      logic [16:0] post;
      logic [31:0] hold;
      logic [31:0] auto_to;
      logic [7:0]  hpos;
      logic [7:0]  wr_ptr;
      logic [16:0] post_cnt;
      logic [31:0] hold_cnt;
      logic [31:0] to_cnt;
      logic [7:0]  prev;
      logic        prev_ok;
      logic [7:0]  trig_ptr;
      logic        released;
      logic [15:0] traces;
      logic [7:0]  rd_ptr;
      logic [31:0] rdata;
      logic        trace_pulse;
      sta_disp_t   disp;
   } sta_state_s_t;
endpackage

// file: verilog/sta_core.sv
// Purpose: sample buffer, trigger detector and trace release of a small scope
// Assumes: samples arrive from synchronous front-end logic with a sample-rate strobe
// Notes: registers over a plain strobe port, read data one cycle later
// Behaviour
// - normal type releases only on trigger when not rolling
// - single type releases once then stops
// - auto releases on trigger or timeout
// - free releases continuously, ignores triggers
// - edge, window, slope modes, direction for edge and slope
// - rising edge crosses level upward
// - falling edge crosses level downward
// - dual edge triggers either direction
// - dual edge when no mode selected
// - logic source toggle flips direction
// - window triggers when leaving level range
// - slope compares consecutive difference to threshold
// - fast time base fills buffer first
// - pre-trigger samples only in fast sampling
// - slow time base passes each sample
// - roll only in slow sampling
// - 256 samples, 128 shown by position
// - slow shows all 256 samples
// - position spans full buffer only stopped
// - time base steps, fast/slow split
// - fastest base hides second analog channel
// - seven gain steps selectable
// - post-trigger count up to 32768
// - hold time blocks further triggers
// - logic source forces edge detection
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sta_map.svh"
module sta_core
   import sta_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int SHOWN = 128
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic [`STA_ADDR_W-1:0]  addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [31:0]                  rdata,
   input  wire logic                    sample_stb,
   input  wire sta_sample_t             sample,
   output sta_disp_t                    disp,
   output logic                         trace_ready,
   output logic                         fast_mode,
   output logic [2:0]                   gain_sel,
   output logic                         roll_active,
   output logic                         acquiring
);
   // elaboration check: pointers are fixed at 8 bits
   if (DEPTH != 256 || SHOWN != DEPTH / 2) begin : g_bad_geometry
      $error("sta_core: buffer geometry must be 256/128");
   end

   sta_sample_t mem [DEPTH];
   sta_state_s_t s;
   sta_state_s_t n;

   logic        fast;
   logic        trig_raw;
   logic        trig;
   logic [7:0]  cur;
   logic        lo_now;
   logic        lo_prev;
   logic        out_now;
   logic        out_prev;
   logic        use_edge;
   logic [8:0]  diff;
   logic [7:0]  mag;
   logic [7:0]  rd_idx;

   assign fast = (s.tb <= `STA_TB_LAST_FAST);

   // logic source picks one input bit, seen as 0x00 or 0xff
   always_comb begin
      if (s.logsrc)
         cur = sample.logic_in[s.lbit] ? 8'hff : 8'h00;
      else if (s.src_ch2)
         cur = sample.second_analog_channel;
      else
         cur = sample.first_analog_channel;
   end

   assign lo_now  = (cur < s.level);
   assign lo_prev = (s.prev < s.level);
   assign out_now  = (cur < s.level) || (cur > s.win_hi);
   assign out_prev = (s.prev < s.level) || (s.prev > s.win_hi);
   assign diff    = {1'b0, cur} - {1'b0, s.prev};
   // magnitude of signed step between samples
   assign mag     = diff[8] ? 8'(~diff[7:0] + 8'h01) : diff[7:0];
   assign use_edge = s.logsrc || (!s.m_win && !s.m_slope);

   always_comb begin
      trig_raw = 1'b0;
      if (s.prev_ok) begin
         if (use_edge) begin
            if (!s.m_edge)
               trig_raw = (lo_prev != lo_now);
            else if (s.dir)
               trig_raw = !lo_prev && lo_now;
            else
               trig_raw = lo_prev && !lo_now;
         end else if (s.m_win)
            // only the step out of the window counts
            // a level test would retrigger on every sample outside
            trig_raw = out_now && !out_prev;
         else
            trig_raw = s.dir ? (diff[8] && mag > s.slope_th) : (!diff[8] && mag > s.slope_th);
      end
   end

   assign trig = trig_raw && (s.hold_cnt == 32'h0);

   assign rd_idx = s.rd_ptr;

   always_comb begin
      n = s;
      n.trace_pulse = 1'b0;
      n.disp.valid  = 1'b0;
      n.rdata       = 32'h0;
      if (s.hold_cnt != 32'h0 && sample_stb)
         n.hold_cnt = s.hold_cnt - 32'h1;

      // register writes
      if (wr) begin
         case (addr)
            `STA_REG_CTRL: begin
               n.run    = wdata[`STA_CTRL_RUN];
               n.roll   = wdata[`STA_CTRL_ROLL];
               n.logsrc = wdata[`STA_CTRL_LOGSRC];
               n.ttype  = sta_type_t'(wdata[`STA_CTRL_TYPE_LO +: 2]);
               if (wdata[`STA_CTRL_TB_LO +: 5] <= `STA_TB_LAST)
                  n.tb = wdata[`STA_CTRL_TB_LO +: 5];
               if (wdata[`STA_CTRL_GAIN_LO +: 3] <= `STA_GAIN_LAST)
                  n.gain = wdata[`STA_CTRL_GAIN_LO +: 3];
               n.lbit   = wdata[`STA_CTRL_LBIT_LO +: 3];
               if (wdata[`STA_CTRL_RUN] && !s.run) begin
                  n.fsm     = STA_ARMED;
                  n.prev_ok = 1'b0;
                  n.to_cnt  = s.auto_to;
               end
            end
            `STA_REG_TRIG: begin
               n.m_edge  = wdata[`STA_TRIG_EDGE];
               n.m_win   = wdata[`STA_TRIG_WIN];
               n.m_slope = wdata[`STA_TRIG_SLOPE];
               n.dir     = wdata[`STA_TRIG_DIR];
               n.src_ch2 = wdata[`STA_TRIG_SRC_CH2];
            end
            `STA_REG_LEVELS: begin
               n.level    = wdata[7:0];
               n.win_hi   = wdata[15:8];
               n.slope_th = wdata[23:16];
            end
            `STA_REG_POST: n.post = (wdata[16:0] > {1'b0, `STA_POST_MAX}) ? {1'b0, `STA_POST_MAX} : wdata[16:0];
            `STA_REG_HOLD: n.hold = wdata;
            `STA_REG_AUTO_TO: n.auto_to = wdata;
            `STA_REG_HPOS: begin
               if (!s.run && fast && wdata[7:0] <= `STA_HPOS_LAST)
                  n.hpos = wdata[7:0];
            end
            `STA_REG_CMD: begin
               if (wdata[`STA_CMD_TOGGLE] && s.logsrc)
                  n.dir = ~s.dir;
               if (wdata[`STA_CMD_CENTER])
                  n.hpos = `STA_HPOS_CENTER;
            end
            `STA_REG_RDPTR: n.rd_ptr = wdata[7:0];
            default: ;
         endcase
      end

      // register reads, answer next cycle
      if (rd) begin
         case (addr)
            `STA_REG_CTRL: n.rdata = {9'h0, s.lbit, 1'b0, s.gain, 3'h0, s.tb, 2'h0, s.ttype, 1'b0,
                                      s.logsrc, s.roll, s.run};
            `STA_REG_TRIG: n.rdata = {27'h0, s.src_ch2, s.dir, s.m_slope, s.m_win, s.m_edge};
            `STA_REG_LEVELS: n.rdata = {8'h0, s.slope_th, s.win_hi, s.level};
            `STA_REG_POST: n.rdata = {15'h0, s.post};
            `STA_REG_HOLD: n.rdata = s.hold;
            `STA_REG_AUTO_TO: n.rdata = s.auto_to;
            `STA_REG_HPOS: n.rdata = {24'h0, s.hpos};
            `STA_REG_STATUS: n.rdata = {s.traces, s.trig_ptr, 3'h0, fast, 1'b0, s.released, s.fsm};
            `STA_REG_RDPTR: n.rdata = {24'h0, s.rd_ptr};
            // window offset by position in fast mode, whole buffer in slow
            // window by position
            `STA_REG_RDDATA: n.rdata = {8'h0, mem[fast ? 8'(rd_idx + s.hpos + s.trig_ptr) : rd_idx]};
            default: n.rdata = 32'h0;
         endcase
      end

      if (sample_stb && s.run) begin
         n.wr_ptr  = s.wr_ptr + 8'h01;
         n.prev    = cur;
         n.prev_ok = 1'b1;
         if (!fast) begin
            n.disp.valid = 1'b1;
            n.disp.smp   = sample;
         end
         case (s.fsm)
            STA_ARMED: begin
               if (s.ttype == STA_AUTO && s.to_cnt != 32'h0)
                  n.to_cnt = s.to_cnt - 32'h1;
               if (s.ttype == STA_FREE || (s.roll && !fast)) begin
                  n.fsm      = STA_POST;
                  n.post_cnt = fast ? 17'(DEPTH) : 17'h0;
                  n.trig_ptr = s.wr_ptr;
               end else if (trig) begin
                  n.to_cnt   = 32'h0;
                  n.hold_cnt = s.hold;
                  n.fsm      = STA_POST;
                  n.trig_ptr = s.wr_ptr;
                  n.post_cnt = fast ? s.post : 17'(DEPTH);
               end else if (s.ttype == STA_AUTO && s.to_cnt == 32'h0) begin
                  n.fsm      = STA_POST;
                  n.trig_ptr = s.wr_ptr;
                  n.post_cnt = fast ? s.post : 17'(DEPTH);
               end
            end
            STA_POST: begin
               if (s.post_cnt > 17'h1)
                  n.post_cnt = s.post_cnt - 17'h1;
               else begin
                  n.trace_pulse = 1'b1;
                  n.released    = 1'b1;
                  n.traces      = s.traces + 16'h1;
                  n.to_cnt      = s.auto_to;
                  if (s.ttype == STA_SINGLE) begin
                     n.fsm = STA_STOPPED;
                     n.run = 1'b0;
                  end else
                     n.fsm = STA_ARMED;
               end
            end
            default: n.fsm = STA_ARMED;
         endcase
      end
      n.disp.second_shown = (s.tb != `STA_TB_FASTEST);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s          <= '0;
         s.post     <= `STA_POST_RST;
         s.auto_to  <= `STA_AUTO_TO_RST;
         s.hpos     <= `STA_HPOS_CENTER;
         s.m_edge   <= 1'b1;
      end else
         s <= n;
      if (sample_stb && s.run)
         mem[s.wr_ptr] <= sample;
   end

   assign rdata       = s.rdata;
   assign disp        = s.disp;
   assign trace_ready = s.trace_pulse;
   assign fast_mode   = fast;
   assign gain_sel    = s.gain;
   assign roll_active = s.roll && !fast;
   assign acquiring   = s.run;

   property p_single_stop;
      @(posedge clk) disable iff (srst)
         (s.trace_pulse && s.ttype == STA_SINGLE && !$past(wr)) |-> !s.run;
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single did not stop");

   property p_roll_slow;
      @(posedge clk) disable iff (srst) roll_active |-> (s.roll && s.tb > `STA_TB_LAST_FAST);
   endproperty
   a_roll_slow: assert property (p_roll_slow) else $error("roll in fast mode");

   property p_ch2_hidden;
      @(posedge clk) disable iff (srst) ($past(s.tb) == `STA_TB_FASTEST) |-> !disp.second_shown;
   endproperty
   a_ch2_hidden: assert property (p_ch2_hidden) else $error("second channel shown at fastest base");

   property p_slow_pass;
      @(posedge clk) disable iff (srst) (sample_stb && s.run && !fast) |=> disp.valid;
   endproperty
   a_slow_pass: assert property (p_slow_pass) else $error("slow sample not passed");

   property p_fast_nopass;
      @(posedge clk) disable iff (srst) (sample_stb && fast) |=> !disp.valid;
   endproperty
   a_fast_nopass: assert property (p_fast_nopass) else $error("fast sample passed directly");

   property p_hold_blocks;
      @(posedge clk) disable iff (srst)
         (s.hold_cnt != 32'h0 && s.fsm == STA_ARMED && sample_stb && s.run && s.ttype == STA_NORMAL
          && !s.roll && !wr) |=> s.fsm == STA_ARMED;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) else $error("trigger inside hold");

   property p_gain_range;
      @(posedge clk) disable iff (srst) gain_sel <= `STA_GAIN_LAST;
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain step out of range");

   property p_post_range;
      @(posedge clk) disable iff (srst) s.post <= {1'b0, `STA_POST_MAX};
   endproperty
   a_post_range: assert property (p_post_range) else $error("post count too large");

   property p_normal_trig;
      @(posedge clk) disable iff (srst)
         (s.ttype == STA_NORMAL && s.fsm == STA_ARMED && sample_stb && s.run && !s.roll && $past(s.ttype) == STA_NORMAL
          && !trig && !wr) |=> s.fsm == STA_ARMED;
   endproperty
   a_normal_trig: assert property (p_normal_trig) else $error("normal left armed without trigger");

   property p_auto_timeout;
      @(posedge clk) disable iff (srst)
         (s.ttype == STA_AUTO && s.fsm == STA_ARMED && sample_stb && s.run && s.to_cnt == 32'h0 && !wr)
         |=> s.fsm == STA_POST;
   endproperty
   a_auto_timeout: assert property (p_auto_timeout) else $error("auto timeout did not release");

   property p_free_ignores;
      @(posedge clk) disable iff (srst)
         (s.ttype == STA_FREE && s.fsm == STA_ARMED && sample_stb && s.run && !wr) |=> s.fsm == STA_POST;
   endproperty
   a_free_ignores: assert property (p_free_ignores) else $error("free type waited for trigger");

   property p_release_restart;
      @(posedge clk) disable iff (srst) s.trace_pulse |-> s.to_cnt == $past(s.auto_to);
   endproperty
   a_release_restart: assert property (p_release_restart) else $error("auto timeout not restarted");
endmodule
`default_nettype wire

// file: bench/sta_front_model.sv
// Purpose: front-end sample source that feeds the acquisition block
// Assumes: one sample strobe every DIV clock cycles, value set by the bench
// Notes: between strobes the first channel and logic lines show the inverse value, the second channel the value itself
`timescale 1ns/1ps
`default_nettype none
module sta_front_model
   import sta_pkg::*;
#(
   parameter int DIV = 4
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [7:0]  ch_val,
   output var  logic        sample_stb,
   output var  sta_sample_t sample
);
   logic [7:0] div_cnt;

   always_ff @(posedge clk) begin
      if (srst) begin
         div_cnt    <= 8'h00;
         sample_stb <= 1'b0;
      end else begin
         div_cnt    <= (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
         sample_stb <= (div_cnt == 8'h00);
      end
   end

   // first channel and logic lines carry the value only under the strobe, the second channel its inverse, so a late sampler sees junk
   always_comb begin
      sample.first_analog_channel  = sample_stb ? ch_val : ~ch_val;
      sample.second_analog_channel = sample_stb ? ~ch_val : ch_val;
      sample.logic_in              = sample_stb ? ch_val : ~ch_val;
   end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench of the trigger and acquisition block
// Assumes: register port with read data one cycle after the read strobe
// Notes: trace releases are counted over windows longer than one buffer fill
`timescale 1ns/1ps
`default_nettype none
`include "sta_map.svh"
module tb_top;
   import sta_pkg::*;
   localparam int W     = 1500;
   localparam int LIMIT = 60000;
   logic        clk;
   logic        srst;
   logic [5:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        sample_stb;
   sta_sample_t sample;
   sta_disp_t   disp;
   logic        trace_ready;
   logic        fast_mode;
   logic [2:0]  gain_sel;
   logic        roll_active;
   logic        acquiring;
   logic [7:0]  ch_val;
   logic [31:0] v;
   int          fail_count;
   int          checks;
   int          ntr;
   int          nv;
   int          ns;
   int          cyc;

   sta_core i_sta_core (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sample_stb(sample_stb), .sample(sample), .disp(disp), .trace_ready(trace_ready),
      .fast_mode(fast_mode), .gain_sel(gain_sel), .roll_active(roll_active), .acquiring(acquiring));
   sta_front_model i_sta_front_model (.clk(clk), .srst(srst), .ch_val(ch_val),
      .sample_stb(sample_stb), .sample(sample));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      if (trace_ready === 1'b1) ntr++;
      if (disp.valid === 1'b1) nv++;
      if (sample_stb === 1'b1) ns++;
      if (cyc == LIMIT) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      // registered outputs settle after the edge
      #1;
   endtask

   task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   function automatic logic [31:0] ctrl(logic run, logic roll, logic ls, logic [1:0] ty, logic [4:0] tb,
                                        logic [2:0] g);
      logic [31:0] c;
      c = 32'h0;
      c[`STA_CTRL_RUN] = run;
      c[`STA_CTRL_ROLL] = roll;
      c[`STA_CTRL_LOGSRC] = ls;
      c[`STA_CTRL_TYPE_LO +: 2] = ty;
      c[`STA_CTRL_TB_LO +: 5] = tb;
      c[`STA_CTRL_GAIN_LO +: 3] = g;
      return c;
   endfunction

   // stop, configure, start at value v0, then count releases over one window
   task automatic arm(input string n, input logic [1:0] ty, input logic [31:0] trg, input logic [31:0] lv,
                      input logic [7:0] v0, input logic any);
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, ty, 5'h02, 3'h0));
      wr_reg(`STA_REG_TRIG, trg);
      wr_reg(`STA_REG_LEVELS, lv);
      @(posedge clk);
      ch_val <= v0;
      wr_reg(`STA_REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, ty, 5'h02, 3'h0));
      ntr = 0;
      repeat (W) @(posedge clk);
      chk(n, 32'(any), any ? 32'(ntr != 0) : 32'(ntr));
   endtask

   task automatic step(input string n, input logic [7:0] nv_in, input int e);
      @(posedge clk);
      ch_val <= nv_in;
      repeat (W) @(posedge clk);
      chk(n, 32'(e), 32'(ntr));
   endtask

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      addr = 6'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      ch_val = 8'h20;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd_reg(`STA_REG_HPOS, v);
      chk("hpos_rst", 32'h40, v);
      chk("ch2_hidden", 32'h0, 32'(disp.second_shown));
      rd_reg(`STA_REG_POST, v);
      chk("post_rst", 32'h80, v);
      rd_reg(`STA_REG_AUTO_TO, v);
      chk("auto_rst", 32'h000f4240, v);
      rd_reg(6'h3c, v);
      chk("unmapped", 32'h0, v);
      wr_reg(`STA_REG_POST, 32'h9000);
      rd_reg(`STA_REG_POST, v);
      chk("post_clamp", 32'h8000, v);
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b1, 1'b0, 2'b00, 5'h0a, 3'h6));
      chk("gain6", 32'h6, 32'(gain_sel));
      chk("fast10", 32'h1, 32'(fast_mode));
      chk("roll_fast", 32'h0, 32'(roll_active));
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b1, 1'b0, 2'b00, 5'h0b, 3'h3));
      chk("slow11", 32'h0, 32'(fast_mode));
      chk("roll_slow", 32'h1, 32'(roll_active));
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 2'b00, 5'h16, 3'h7));
      chk("gain_bad", 32'h3, 32'(gain_sel));
      chk("tb_bad", 32'h0, 32'(fast_mode));
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, 2'b00, 5'h02, 3'h0));
      wr_reg(`STA_REG_TRIG, 32'h1);
      wr_reg(`STA_REG_CMD, 32'h1);
      rd_reg(`STA_REG_TRIG, v);
      chk("toggle1", 32'h1, 32'(v[`STA_TRIG_DIR]));
      wr_reg(`STA_REG_CMD, 32'h1);
      rd_reg(`STA_REG_TRIG, v);
      chk("toggle2", 32'h0, 32'(v[`STA_TRIG_DIR]));
      wr_reg(`STA_REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, 2'b00, 5'h02, 3'h0));
      wr_reg(`STA_REG_HPOS, 32'h10);
      rd_reg(`STA_REG_HPOS, v);
      chk("hpos_run", 32'h40, v);
      wr_reg(`STA_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 2'b00, 5'h02, 3'h0));
      wr_reg(`STA_REG_HPOS, 32'h10);
      rd_reg(`STA_REG_HPOS, v);
      chk("hpos_stop", 32'h10, v);
      wr_reg(`STA_REG_CMD, 32'h2);
      rd_reg(`STA_REG_HPOS, v);
      chk("hpos_center", 32'h40, v);
      $display("test registers done");
      wr_reg(`STA_REG_POST, 32'h4);
      wr_reg(`STA_REG_HOLD, 32'h0);
      wr_reg(`STA_REG_AUTO_TO, 32'h5);
      arm("rise_idle", STA_NORMAL, 32'h1, 32'h80, 8'h20, 1'b0);
      step("rise_up", 8'hc0, 1);
      step("rise_down", 8'h20, 1);
      $display("test rising done");
      arm("fall_idle", STA_NORMAL, 32'h9, 32'h80, 8'hc0, 1'b0);
      step("fall_down", 8'h20, 1);
      $display("test falling done");
      arm("single_idle", STA_SINGLE, 32'h1, 32'h80, 8'h20, 1'b0);
      step("single_1", 8'hc0, 1);
      step("single_2", 8'h20, 1);
      step("single_3", 8'hc0, 1);
      chk("single_stop", 32'h0, 32'(acquiring));
      $display("test single done");
      arm("auto_timeout", STA_AUTO, 32'h1, 32'h80, 8'h20, 1'b1);
      arm("free_run", STA_FREE, 32'h1, 32'h80, 8'h20, 1'b1);
      $display("test auto and free done");
      arm("dual_idle", STA_NORMAL, 32'h0, 32'h80, 8'h20, 1'b0);
      step("dual_up", 8'hc0, 1);
      step("dual_down", 8'h20, 2);
      $display("test dual done");
      arm("win_inside", STA_NORMAL, 32'h2, 32'h0000c040, 8'h80, 1'b0);
      step("win_leave", 8'hf0, 1);
      $display("test window done");
      arm("slope_idle", STA_NORMAL, 32'h4, 32'h00200080, 8'h20, 1'b0);
      step("slope_small", 8'h30, 0);
      step("slope_big", 8'h90, 1);
      $display("test slope done");
      wr_reg(`STA_REG_HOLD, 32'h3e8);
      arm("hold_idle", STA_NORMAL, 32'h1, 32'h80, 8'h20, 1'b0);
      step("hold_first", 8'hc0, 1);
      step("hold_down", 8'h20, 1);
      step("hold_block", 8'hc0, 1);
      $display("test hold done");
      wr_reg(`STA_REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, STA_FREE, 5'h0b, 3'h0));
      repeat (8) @(posedge clk);
      nv = 0;
      ns = 0;
      repeat (400) @(posedge clk);
      chk("slow_per_sample", 32'h1, 32'((nv - ns) <= 1 && (ns - nv) <= 1));
      chk("slow_data", 32'h00c03fc0, 32'(disp.smp));
      chk("ch2_shown", 32'h1, 32'(disp.second_shown));
      wr_reg(`STA_REG_RDPTR, 32'hff);
      rd_reg(`STA_REG_RDDATA, v);
      chk("buf_slow", 32'h00c03fc0, v);
      $display("test slow done");
      end_sim();
   end
endmodule
`default_nettype wire
